// file: inc/sdireg_consts.svh
`ifndef SDIREG_CONSTS_SVH
`define SDIREG_CONSTS_SVH

// register offsets (word index on the register port)
`define SDIREG_OFS_CTRL        12'h000
`define SDIREG_OFS_RX_FLAGS    12'h002
`define SDIREG_OFS_PGM_FLAGS   12'h003
`define SDIREG_OFS_FMT_STATUS  12'h004
`define SDIREG_OFS_RES_BLK_A   12'h005
`define SDIREG_OFS_STD_OVR     12'h006
`define SDIREG_OFS_VALIDITY    12'h007
`define SDIREG_OFS_PLACEMENT   12'h008
`define SDIREG_OFS_RES_BLK_B   12'h009
`define SDIREG_OFS_L1_B12      12'h00A
`define SDIREG_OFS_L1_B34      12'h00B
`define SDIREG_OFS_L2_B12      12'h00C
`define SDIREG_OFS_L2_B34      12'h00D
`define SDIREG_OFS_INT_STATUS  12'h030
`define SDIREG_OFS_INT_CLEAR   12'h031
`define SDIREG_OFS_INT_ENABLE  12'h032

// control register fields
`define SDIREG_CTRL_FLAGSRC_BIT 12
`define SDIREG_CTRL_INSDIS_BIT  6

// error flag layout
`define SDIREG_FLAGS_MSB       14
`define SDIREG_PGM_FLAGS_MSB   13

// format status fields
`define SDIREG_FMT_STD_MSB     9
`define SDIREG_FMT_STD_LSB     5
`define SDIREG_FMT_INTL_BIT    4
`define SDIREG_FMT_CONV_BIT    3
`define SDIREG_FMT_SLOCK_BIT   2
`define SDIREG_FMT_VLOCK_BIT   1
`define SDIREG_FMT_HLOCK_BIT   0

// standard override fields
`define SDIREG_OVR_EN_BIT      5
`define SDIREG_OVR_STD_MSB     4

// validity fields
`define SDIREG_VAL_FF_BIT      1
`define SDIREG_VAL_AP_BIT      0

// placement field
`define SDIREG_PLACE_BIT       0

// interrupt bits
`define SDIREG_INT_PKT_BIT     0
`define SDIREG_INT_LOCK_BIT    1
`define SDIREG_INT_STD_BIT     2

// reset values
`define SDIREG_RST_CTRL        16'h0000
`define SDIREG_RST_PGM_FLAGS   16'h0000
`define SDIREG_RST_STD_OVR     16'h0000
`define SDIREG_RST_PLACEMENT   16'h0001
`define SDIREG_RST_PAYLOAD     16'h0000
`define SDIREG_RST_INT_ENABLE  16'h0000

`endif

// file: inc/sdireg_pkg.sv
package sdireg_pkg;

    // status delivered by the video datapath, same clock
    typedef struct packed {
        logic edhPktValid;
        logic [14:0] edhFlags;
        logic fullFieldValidBit;
        logic activePictureValidBit;
        logic [4:0] detectedStandardCode;
        logic interlacedFlag;
        logic conversionLocked;
        logic standardLocked;
        logic verticalLocked;
        logic horizontalLocked;
    } sdireg_rxstat_t;

    // configuration handed to the transmit datapath
    typedef struct packed {
        logic [14:0] txErrorFlags;
        logic flagSourceSelect;
        logic [4:0] effectiveStandardCode;
        logic payloadIdInsertEnable;
        logic payloadIdEarlyPlacement;
        logic [31:0] link1PayloadBytes;
        logic [31:0] link2PayloadBytes;
    } sdireg_txcfg_t;

    // whole register state of the bank
    typedef struct packed {
        logic [15:0] rdData;
        logic irq;
        logic flagSourceSelect;
        logic payloadIdInsertDisable;
        logic [14:0] rxFlags;
        logic [13:0] pgmFlags;
        logic [9:0] fmtStatus;
        logic standardOverrideEnable;
        logic [4:0] overrideStandardCode;
        logic fullFieldValidBit;
        logic activePictureValidBit;
        logic payloadIdEarlyPlacement;
        logic [31:0] link1Bytes;
        logic [31:0] link2Bytes;
        logic [2:0] intStatus;
        logic [2:0] intEnable;
        sdireg_txcfg_t txCfg;
    } sdireg_state_t;

endpackage

// file: core/sdireg_top.sv
// Function
// RULE1 - Received error flags read back in bits 14..0 as three groups of five: ancillary, full field, active picture.
// RULE2 - Outgoing error flags use the same layout, bits 13..0 host writable, bit 14 read only.
// RULE3 - Control bit 12 set forwards the received flags into outgoing packets, clear uses the programmed ones.
// RULE4 - Format status shows the detected standard code in bits 9..5 and interlaced in bit 4.
// RULE5 - Format status shows standard, vertical and horizontal lock in bits 2, 1 and 0, active high.
// RULE6 - Format status bit 3 is high while format conversion is locked.
// RULE7 - Override bit 5 high makes the host code in bits 4..0 replace the detected standard.
// RULE8 - Validity status shows the full field bit in bit 1 and the active picture bit in bit 0, read only.
// RULE9 - Placement bit 0, reset 1, selects first available space, else right after the line end words.
// RULE10 - Link one payload bytes 2/1 and 4/3 sit in two registers, even byte high, odd byte low.
// RULE11 - Link two payload bytes 2 and 1 sit in one register, byte 2 high and byte 1 low.
// RULE12 - Link two payload bytes 4 and 3 sit in the next register, byte 4 high and byte 3 low.
// RULE13 - Control bit 6 high stops payload identifier insertion whatever else is set.
// RULE14 - Received flags and validity bits update on each complete packet; reserved bits read zero.
// RULE15 - The host writes payload bytes and flags before enabling insertion and writes zero to reserved bits.
`timescale 1ns/10ps
`include "sdireg_consts.svh"

module sdireg_top #(
    parameter int AW = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [AW-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [15:0] regRdData,
    // interrupt
    output logic irq,
    // video datapath
    input wire sdireg_pkg::sdireg_rxstat_t rxStat,
    output sdireg_pkg::sdireg_txcfg_t txCfg
);

    sdireg_pkg::sdireg_state_t stateQ;
    sdireg_pkg::sdireg_state_t stateD;

    function automatic logic hit(input logic [AW-1:0] a, input logic [11:0] ofs);
        return a == AW'(ofs);
    endfunction

    function automatic logic [15:0] readMux(input logic [AW-1:0] a,
                                            input sdireg_pkg::sdireg_state_t st);
        logic [15:0] v;
        v = 16'h0000;
        if (hit(a, `SDIREG_OFS_CTRL)) begin
            v[`SDIREG_CTRL_FLAGSRC_BIT] = st.flagSourceSelect;
            v[`SDIREG_CTRL_INSDIS_BIT] = st.payloadIdInsertDisable;
        end else if (hit(a, `SDIREG_OFS_RX_FLAGS)) begin
            v[`SDIREG_FLAGS_MSB:0] = st.rxFlags; // [RULE1]
        end else if (hit(a, `SDIREG_OFS_PGM_FLAGS)) begin
            v[`SDIREG_PGM_FLAGS_MSB:0] = st.pgmFlags; // [RULE2]
        end else if (hit(a, `SDIREG_OFS_FMT_STATUS)) begin
            v[`SDIREG_FMT_STD_MSB:0] = st.fmtStatus; // [RULE4] [RULE5] [RULE6]
        end else if (hit(a, `SDIREG_OFS_STD_OVR)) begin
            v[`SDIREG_OVR_EN_BIT] = st.standardOverrideEnable;
            v[`SDIREG_OVR_STD_MSB:0] = st.overrideStandardCode;
        end else if (hit(a, `SDIREG_OFS_VALIDITY)) begin
            v[`SDIREG_VAL_FF_BIT] = st.fullFieldValidBit; // [RULE8]
            v[`SDIREG_VAL_AP_BIT] = st.activePictureValidBit;
        end else if (hit(a, `SDIREG_OFS_PLACEMENT)) begin
            v[`SDIREG_PLACE_BIT] = st.payloadIdEarlyPlacement;
        end else if (hit(a, `SDIREG_OFS_L1_B12)) begin
            v = st.link1Bytes[15:0];
        end else if (hit(a, `SDIREG_OFS_L1_B34)) begin
            v = st.link1Bytes[31:16];
        end else if (hit(a, `SDIREG_OFS_L2_B12)) begin
            v = st.link2Bytes[15:0];
        end else if (hit(a, `SDIREG_OFS_L2_B34)) begin
            v = st.link2Bytes[31:16];
        end else if (hit(a, `SDIREG_OFS_INT_STATUS)) begin
            v[2:0] = st.intStatus;
        end else if (hit(a, `SDIREG_OFS_INT_ENABLE)) begin
            v[2:0] = st.intEnable;
        end
        // reserved blocks, the clear register and unmapped space read zero
        return v; // [RULE14]
    endfunction

    always_comb begin
        logic [9:0] fmtNow;
        logic [2:0] events;
        logic [2:0] clearMask;
        stateD = stateQ;
        fmtNow = 10'h000;
        events = 3'h0;
        clearMask = 3'h0;

        // read data stands only in the cycle after the strobe
        stateD.rdData = regRdStb ? readMux(regAddr, stateQ) : 16'h0000;

        // live format status, sampled every cycle
        fmtNow[`SDIREG_FMT_STD_MSB:`SDIREG_FMT_STD_LSB] = rxStat.detectedStandardCode; // [RULE4]
        fmtNow[`SDIREG_FMT_INTL_BIT] = rxStat.interlacedFlag; // [RULE4]
        fmtNow[`SDIREG_FMT_CONV_BIT] = rxStat.conversionLocked; // [RULE6]
        fmtNow[`SDIREG_FMT_SLOCK_BIT] = rxStat.standardLocked; // [RULE5]
        fmtNow[`SDIREG_FMT_VLOCK_BIT] = rxStat.verticalLocked; // [RULE5]
        fmtNow[`SDIREG_FMT_HLOCK_BIT] = rxStat.horizontalLocked; // [RULE5]
        stateD.fmtStatus = fmtNow;

        // captured packet contents
        if (rxStat.edhPktValid) begin
            stateD.rxFlags = rxStat.edhFlags; // [RULE1] [RULE14]
            stateD.fullFieldValidBit = rxStat.fullFieldValidBit; // [RULE8] [RULE14]
            stateD.activePictureValidBit = rxStat.activePictureValidBit; // [RULE8] [RULE14]
        end

        // events: packet seen, any lock bit changed, standard code changed
        events[`SDIREG_INT_PKT_BIT] = rxStat.edhPktValid;
        events[`SDIREG_INT_LOCK_BIT] =
            fmtNow[`SDIREG_FMT_CONV_BIT:0] != stateQ.fmtStatus[`SDIREG_FMT_CONV_BIT:0];
        events[`SDIREG_INT_STD_BIT] =
            fmtNow[`SDIREG_FMT_STD_MSB:`SDIREG_FMT_STD_LSB]
            != stateQ.fmtStatus[`SDIREG_FMT_STD_MSB:`SDIREG_FMT_STD_LSB];

        // host writes; read-only locations ignore them
        if (regWrStb) begin
            if (hit(regAddr, `SDIREG_OFS_CTRL)) begin
                stateD.flagSourceSelect = regWrData[`SDIREG_CTRL_FLAGSRC_BIT];
                stateD.payloadIdInsertDisable = regWrData[`SDIREG_CTRL_INSDIS_BIT];
            end
            if (hit(regAddr, `SDIREG_OFS_PGM_FLAGS)) begin
                // ancillary unknown-status stays read only
                stateD.pgmFlags = regWrData[`SDIREG_PGM_FLAGS_MSB:0]; // [RULE2]
            end
            if (hit(regAddr, `SDIREG_OFS_STD_OVR)) begin
                stateD.standardOverrideEnable = regWrData[`SDIREG_OVR_EN_BIT];
                stateD.overrideStandardCode = regWrData[`SDIREG_OVR_STD_MSB:0];
            end
            if (hit(regAddr, `SDIREG_OFS_PLACEMENT)) begin
                stateD.payloadIdEarlyPlacement = regWrData[`SDIREG_PLACE_BIT];
            end
            if (hit(regAddr, `SDIREG_OFS_L1_B12)) begin
                stateD.link1Bytes[15:0] = regWrData; // [RULE10]
            end
            if (hit(regAddr, `SDIREG_OFS_L1_B34)) begin
                stateD.link1Bytes[31:16] = regWrData; // [RULE10]
            end
            if (hit(regAddr, `SDIREG_OFS_L2_B12)) begin
                stateD.link2Bytes[15:0] = regWrData; // [RULE11]
            end
            if (hit(regAddr, `SDIREG_OFS_L2_B34)) begin
                stateD.link2Bytes[31:16] = regWrData; // [RULE12]
            end
            if (hit(regAddr, `SDIREG_OFS_INT_CLEAR)) begin
                clearMask = regWrData[2:0];
            end
            if (hit(regAddr, `SDIREG_OFS_INT_ENABLE)) begin
                stateD.intEnable = regWrData[2:0];
            end
        end

        // a new event wins over a clear in the same cycle
        stateD.intStatus = (stateQ.intStatus & ~clearMask) | events;
        stateD.irq = |(stateD.intStatus & stateD.intEnable);

        // transmit configuration follows the next register values
        stateD.txCfg.flagSourceSelect = stateD.flagSourceSelect;
        stateD.txCfg.txErrorFlags = stateD.flagSourceSelect ? stateD.rxFlags
                                    : {1'b0, stateD.pgmFlags}; // [RULE3]
        stateD.txCfg.effectiveStandardCode = stateD.standardOverrideEnable
            ? stateD.overrideStandardCode
            : fmtNow[`SDIREG_FMT_STD_MSB:`SDIREG_FMT_STD_LSB]; // [RULE7]
        stateD.txCfg.payloadIdInsertEnable = !stateD.payloadIdInsertDisable; // [RULE13]
        stateD.txCfg.payloadIdEarlyPlacement = stateD.payloadIdEarlyPlacement; // [RULE9]
        // byte 1 lowest, byte 4 highest on the carrier
        stateD.txCfg.link1PayloadBytes = stateD.link1Bytes; // [RULE10]
        stateD.txCfg.link2PayloadBytes = stateD.link2Bytes; // [RULE11] [RULE12]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= '0;
            stateQ.flagSourceSelect <= 1'(`SDIREG_RST_CTRL >> `SDIREG_CTRL_FLAGSRC_BIT);
            stateQ.payloadIdInsertDisable <= 1'(`SDIREG_RST_CTRL >> `SDIREG_CTRL_INSDIS_BIT);
            stateQ.pgmFlags <= 14'(`SDIREG_RST_PGM_FLAGS);
            stateQ.standardOverrideEnable <= 1'(`SDIREG_RST_STD_OVR >> `SDIREG_OVR_EN_BIT);
            stateQ.overrideStandardCode <= 5'(`SDIREG_RST_STD_OVR);
            stateQ.payloadIdEarlyPlacement <=
                1'(`SDIREG_RST_PLACEMENT >> `SDIREG_PLACE_BIT); // [RULE9]
            stateQ.link1Bytes <= {`SDIREG_RST_PAYLOAD, `SDIREG_RST_PAYLOAD};
            stateQ.link2Bytes <= {`SDIREG_RST_PAYLOAD, `SDIREG_RST_PAYLOAD};
            stateQ.intEnable <= 3'(`SDIREG_RST_INT_ENABLE);
            stateQ.txCfg.payloadIdInsertEnable <= 1'b1;
            stateQ.txCfg.payloadIdEarlyPlacement <=
                1'(`SDIREG_RST_PLACEMENT >> `SDIREG_PLACE_BIT);
        end else begin
            stateQ <= stateD;
        end
    end

    assign regRdData = stateQ.rdData;
    assign irq = stateQ.irq;
    assign txCfg = stateQ.txCfg;

endmodule // sdireg_top

// file: verif/sdireg_assertions.sv
`timescale 1ns/10ps
module sdireg_chk #(
    parameter int AW = 12
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [AW-1:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [15:0] regRdData,
    input wire logic irq,
    // video datapath
    input wire sdireg_pkg::sdireg_rxstat_t rxStat,
    input wire sdireg_pkg::sdireg_txcfg_t txCfg
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [16:0] capFlags_q;
    logic [9:0] fmtNow;
    assign fmtNow = {rxStat.detectedStandardCode, rxStat.interlacedFlag,
        rxStat.conversionLocked, rxStat.standardLocked, rxStat.verticalLocked,
        rxStat.horizontalLocked};
    // last packet seen by the datapath
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capFlags_q <= '0;
        end else if (rxStat.edhPktValid) begin
            capFlags_q <= {rxStat.edhFlags, rxStat.fullFieldValidBit,
                rxStat.activePictureValidBit};
        end
    end
    a_idle_read_zero: assert property (!regRdStb |=> regRdData == 16'h0000)
        else $error("read data not idle");
    a_rx_flags_read: assert property (
        regRdStb && regAddr == 12'h002 |=> regRdData == {1'b0, $past(capFlags_q[16:2])})
        else $error("received flags read wrong");
    a_validity_read: assert property (
        regRdStb && regAddr == 12'h007 |=> regRdData == {14'h0000, $past(capFlags_q[1:0])})
        else $error("validity bits read wrong");
    a_format_live: assert property (
        regRdStb && regAddr == 12'h004 && $past(rst_n)
        |=> regRdData == {6'h00, $past(fmtNow, 2)})
        else $error("format status read wrong");
    a_flag_forward: assert property (
        rxStat.edhPktValid ##1 (txCfg.flagSourceSelect && !rxStat.edhPktValid) [*2]
        |-> txCfg.txErrorFlags == $past(rxStat.edhFlags, 2))
        else $error("forwarded flags wrong");
    a_pgm_flags: assert property (
        (regWrStb && regAddr == 12'h003 && !txCfg.flagSourceSelect)
        ##1 (!txCfg.flagSourceSelect && !(regWrStb && regAddr == 12'h003))
        |=> txCfg.txErrorFlags == {1'b0, $past(regWrData[13:0], 2)})
        else $error("programmed flags wrong");
    a_std_override: assert property (
        regWrStb && regAddr == 12'h006 && regWrData[5]
        |=> txCfg.effectiveStandardCode == $past(regWrData[4:0]))
        else $error("forced standard not used");
    a_ctrl_bits: assert property (regWrStb && regAddr == 12'h000 |=>
        txCfg.payloadIdInsertEnable == !$past(regWrData[6])
        && txCfg.flagSourceSelect == $past(regWrData[12]))
        else $error("control bits wrong");
    a_placement_bit: assert property (
        regWrStb && regAddr == 12'h008 |=> txCfg.payloadIdEarlyPlacement == $past(regWrData[0]))
        else $error("placement wrong");
    a_link1_bytes: assert property (regWrStb && regAddr[11:1] == 11'h005 |=>
        ($past(regAddr[0]) ? txCfg.link1PayloadBytes[31:16] : txCfg.link1PayloadBytes[15:0])
        == $past(regWrData))
        else $error("link one bytes wrong");
    a_link2_bytes: assert property (regWrStb && regAddr[11:1] == 11'h006 |=>
        ($past(regAddr[0]) ? txCfg.link2PayloadBytes[31:16] : txCfg.link2PayloadBytes[15:0])
        == $past(regWrData))
        else $error("link two bytes wrong");
endmodule // sdireg_chk

bind sdireg_top sdireg_chk #(.AW(AW)) chk_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .irq(irq), .rxStat(rxStat), .txCfg(txCfg));

// file: verif/sdireg_host.sv
`timescale 1ns/10ps
module sdireg_host #(
    parameter int AW = 12
) (
    // clock and read return
    input wire logic clk,
    input wire logic [15:0] regRdData,
    // requests
    output logic [AW-1:0] regAddr = '0,
    output logic [15:0] regWrData = '0,
    output logic regWrStb = 1'b0,
    output logic regRdStb = 1'b0
);
    // released lines carry junk so stale values are never trusted
    task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge clk);
        regWrStb <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge clk);
        regRdStb <= 1'b0;
        regAddr <= ~a;
        @(posedge clk);
        d = regRdData;
    endtask
endmodule // sdireg_host

// file: verif/sdireg_top_test.sv
`timescale 1ns/10ps
module sdireg_top_test;
    logic clk, rst_n, regWrStb, regRdStb, irq;
    logic [11:0] regAddr;
    logic [15:0] regWrData, regRdData;
    sdireg_pkg::sdireg_rxstat_t rxStat;
    sdireg_pkg::sdireg_txcfg_t txCfg;
    int badCount = 0;
    int testsRun = 0;
    logic [11:0] ra [15] = '{12'h000, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h007,
        12'h008, 12'h009, 12'h00A, 12'h00B, 12'h00C, 12'h00D, 12'h032, 12'h0FF};
    logic [15:0] rm [15] = '{16'h1040, 16'h0000, 16'h3FFF, 16'h0000, 16'h0000, 16'h003F,
        16'h0000, 16'h0001, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0007, 16'h0000};
    sdireg_top dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .irq(irq),
        .rxStat(rxStat), .txCfg(txCfg));
    sdireg_host host_u (.clk(clk), .regRdData(regRdData), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb));
    task automatic completeRun();
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            badCount++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [15:0] e);
        logic [15:0] d;
        host_u.rd(a, d);
        chk($sformatf("register %0h", a), {16'h0000, e}, {16'h0000, d});
    endtask
    task automatic pkt(input logic [14:0] f, input logic [1:0] v);
        @(posedge clk);
        rxStat.edhPktValid <= 1'b1;
        rxStat.edhFlags <= f;
        {rxStat.fullFieldValidBit, rxStat.activePictureValidBit} <= v;
        @(posedge clk);
        rxStat.edhPktValid <= 1'b0;
        rxStat.edhFlags <= ~f;
        {rxStat.fullFieldValidBit, rxStat.activePictureValidBit} <= ~v;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        badCount++;
        completeRun();
    end
    initial begin
        rst_n = 1'b0;
        rxStat = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ra[i]) rdc(ra[i], (ra[i] == 12'h008) ? 16'h0001 : 16'h0000);
        chk("reset txcfg", 32'h3, {30'h0, txCfg.payloadIdInsertEnable,
            txCfg.payloadIdEarlyPlacement});
        for (int p = 0; p < 2; p++) begin
            foreach (ra[i]) begin
                host_u.wr(ra[i], p ? 16'h5AA5 : 16'hFFFF);
                rdc(ra[i], (p ? 16'h5AA5 : 16'hFFFF) & rm[i]);
            end
        end
        // payload first, insertion enabled afterwards
        host_u.wr(12'h00A, 16'h2211);
        host_u.wr(12'h00B, 16'h4433);
        host_u.wr(12'h00C, 16'h6655);
        host_u.wr(12'h00D, 16'h8877);
        host_u.wr(12'h000, 16'h1000);
        host_u.wr(12'h008, 16'h0000);
        @(posedge clk);
        chk("link1 bytes", 32'h44332211, txCfg.link1PayloadBytes);
        chk("link2 bytes", 32'h88776655, txCfg.link2PayloadBytes);
        chk("insert enable", 32'h1, {31'h0, txCfg.payloadIdInsertEnable});
        chk("placement", 32'h0, {31'h0, txCfg.payloadIdEarlyPlacement});
        host_u.wr(12'h032, 16'h0001);
        pkt(15'h4B2D, 2'b10);
        chk("irq raised", 32'h1, {31'h0, irq});
        chk("forwarded flags", 32'h4B2D, {17'h0, txCfg.txErrorFlags});
        rdc(12'h002, 16'h4B2D);
        rdc(12'h007, 16'h0002);
        rdc(12'h030, 16'h0001);
        host_u.wr(12'h031, 16'h0001);
        repeat (2) @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        host_u.wr(12'h032, 16'h0000);
        pkt(15'h34D2, 2'b01);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdc(12'h030, 16'h0001);
        rdc(12'h007, 16'h0001);
        host_u.wr(12'h000, 16'h0040);
        host_u.wr(12'h003, 16'h7FFF);
        @(posedge clk);
        chk("programmed flags", 32'h3FFF, {17'h0, txCfg.txErrorFlags});
        chk("insert enable", 32'h0, {31'h0, txCfg.payloadIdInsertEnable});
        {rxStat.detectedStandardCode, rxStat.interlacedFlag, rxStat.conversionLocked,
            rxStat.standardLocked, rxStat.verticalLocked, rxStat.horizontalLocked} <= 10'h2BD;
        repeat (3) @(posedge clk);
        rdc(12'h004, 16'h02BD);
        rdc(12'h030, 16'h0007);
        host_u.wr(12'h031, 16'h0007);
        rdc(12'h030, 16'h0000);
        host_u.wr(12'h006, 16'h0023);
        @(posedge clk);
        chk("forced standard", 32'h03, {27'h0, txCfg.effectiveStandardCode});
        host_u.wr(12'h006, 16'h0003);
        @(posedge clk);
        chk("detected standard", 32'h15, {27'h0, txCfg.effectiveStandardCode});
        completeRun();
    end
endmodule // sdireg_top_test
